// [tsir_i2c_host.sv]
`timescale 1ns/1ps
// Bus controller model; released lines float high on the pull-up
module tsir_i2c_host #(
    parameter int QTR = 25
) (
    // Clock
    input wire logic core_clk,
    // Bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Quarter bit; 100 cycles a bit holds the rate at 400 kb/s
    task automatic q();
        repeat (QTR) @(negedge core_clk);
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    // Stop: data rises while clock is high
    task automatic stop();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask
    // Nine clocks, first bit most significant; data only moves with clock low
    task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~tx[i];
            q();
            scl = 1'b1;
            q();
            rx[i] = sda;
            q();
            scl = 1'b0;
            q();
        end
    endtask
endmodule

// [tsir_output_decode.sv]
`timescale 1ns/1ps
module tsir_output_decode (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Gating terms
    input wire logic port_enable,
    input wire logic active,
    input wire logic squelched,
    // Port output register
    input wire logic [7:0] setup,
    // Driver controls
    output logic drv_on,
    output logic drv_double_term,
    output logic [2:0] drv_emphasis,
    output logic [1:0] drv_swing,
    output logic [1:0] drv_slew
);
    logic next_on;
    logic [2:0] next_emp;

    // Any 1xx emphasis code maps to the single 6 dB setting
    always_comb begin
        next_on = port_enable & active & ~squelched;
        next_emp = setup[tsir_pkg::TX_EMP_LSB +: 3];
        if (next_emp[2]) begin
            next_emp = 3'h4;
        end
    end

    // Registered so the analog controls never glitch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drv_on <= 1'b0;
            drv_double_term <= 1'b0;
            drv_emphasis <= 3'h0;
            drv_swing <= 2'h0;
            drv_slew <= 2'h0;
        end else begin
            drv_on <= next_on;
            drv_double_term <= setup[tsir_pkg::TX_DOUBLE_TERM_BIT];
            drv_emphasis <= next_emp;
            drv_swing <= setup[tsir_pkg::TX_SWING_LSB +: 2];
            drv_slew <= setup[tsir_pkg::TX_SLEW_LSB +: 2];
        end
    end
endmodule

// [tsir_pin_sync.sv]
`timescale 1ns/1ps
module tsir_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pin side
    input wire logic [WIDTH-1:0] pin_in,
    // Filtered level
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // Accept a change only when the last two stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    // Three stage chain; the first stage feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            level <= INIT;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end
endmodule

// [tsir_pkg.sv]
package tsir_pkg;
    // Register offsets
    localparam logic [2:0] OFS_GENERAL_CONFIG = 3'h0;
    localparam logic [2:0] OFS_RECEIVER_SETUP = 3'h1;
    localparam logic [2:0] OFS_SPARE_TWO = 3'h2;
    localparam logic [2:0] OFS_PORT_ONE_OUTPUT_SETUP = 3'h3;
    localparam logic [2:0] OFS_PORT_TWO_OUTPUT_SETUP = 3'h4;
    localparam logic [2:0] OFS_SPARE_FIVE = 3'h5;
    localparam logic [2:0] OFS_SPARE_SIX = 3'h6;
    localparam logic [2:0] OFS_SPARE_SEVEN = 3'h7;
    localparam int REG_COUNT = 8;
    // Reset values
    localparam logic [7:0] RST_GENERAL_CONFIG = 8'hff;
    localparam logic [7:0] RST_RECEIVER_SETUP = 8'h00;
    localparam logic [7:0] RST_SPARE_TWO = 8'h00;
    localparam logic [7:0] RST_PORT_ONE_OUTPUT_SETUP = 8'h00;
    localparam logic [7:0] RST_PORT_TWO_OUTPUT_SETUP = 8'h00;
    localparam logic [7:0] RST_SPARE_FIVE = 8'h00;
    localparam logic [7:0] RST_SPARE_SIX = 8'h0f;
    localparam logic [7:0] RST_SPARE_SEVEN = 8'h00;
    // Address pattern
    localparam logic [2:0] TARGET_ADDR_UPPER = 3'h5;
    // Field positions
    localparam int CFG_NORMAL_BIT = 7;
    localparam int CFG_PORT1_EN_BIT = 5;
    localparam int CFG_PORT2_EN_BIT = 4;
    localparam int RX_TERM_OFF_BIT = 7;
    localparam int RX_BIAS_VDD_BIT = 6;
    localparam int RX_BIAS_EN_BIT = 5;
    localparam int RX_EQ_LSB = 2;
    localparam int RX_SQ_OFF_BIT = 1;
    localparam int TX_DOUBLE_TERM_BIT = 7;
    localparam int TX_EMP_LSB = 4;
    localparam int TX_SWING_LSB = 2;
    localparam int TX_SLEW_LSB = 0;
    // Pin input synchroniser depth
    localparam int SYNC_DEPTH = 3;
    // Target states
    typedef enum logic [2:0] {
        TSIR_IDLE = 3'b000,
        TSIR_ADDR = 3'b001,
        TSIR_ADDR_ACK = 3'b010,
        TSIR_WR_BYTE = 3'b011,
        TSIR_WR_ACK = 3'b100,
        TSIR_RD_BYTE = 3'b101,
        TSIR_RD_ACK = 3'b110
    } tsir_state_e;
endpackage

// [tsir_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - I2C target on dedicated pins, 400 kb/s
// - Address 101 plus four strap bits
// - Address LSB one reads, zero writes
// - Eight read/write byte registers, offsets 0-7
// - Config bit 7 zero gives standby
// - Config bits 5,4 enable ports 1,2
// - Receiver bit 7 one disconnects termination
// - Bias bit 6 applies only when bit 5
// - Receiver bits 4:2 pick equalizer gain
// - Receiver bit 1 zero enables squelch
// - Separate output registers per port
// - Output bit 7 picks driver type
// - Bits 6:4 pick pre-emphasis, 1xx is 6 dB
// - Bits 3:2 adjust output swing
// - Bits 1:0 adjust slew rate
// - Squelch disables outputs on weak clock
// - Mode pin high; output enable low disables
module tsir_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control bus pins
    input wire logic ctrl_bus_clock,
    input wire logic ctrl_bus_data_in,
    output logic ctrl_bus_data_out,
    output logic ctrl_bus_data_oe,
    // Straps and control pins
    input wire logic [3:0] addr_strap,
    input wire logic control_source_select,
    input wire logic output_enable_pin,
    input wire logic clock_level_ok,
    // Receiver controls
    output logic eq_powered,
    output logic term_connected,
    output logic bias_override,
    output logic bias_to_supply,
    output logic [2:0] eq_gain,
    output logic squelch_enabled,
    // Port 1 driver controls
    output logic p1_on,
    output logic p1_double_term,
    output logic [2:0] p1_emphasis,
    output logic [1:0] p1_swing,
    output logic [1:0] p1_slew,
    // Port 2 driver controls
    output logic p2_on,
    output logic p2_double_term,
    output logic [2:0] p2_emphasis,
    output logic [1:0] p2_swing,
    output logic [1:0] p2_slew
);
    localparam logic [7:0] RST_VALS [tsir_pkg::REG_COUNT] = '{
        tsir_pkg::RST_GENERAL_CONFIG, tsir_pkg::RST_RECEIVER_SETUP, tsir_pkg::RST_SPARE_TWO,
        tsir_pkg::RST_PORT_ONE_OUTPUT_SETUP, tsir_pkg::RST_PORT_TWO_OUTPUT_SETUP,
        tsir_pkg::RST_SPARE_FIVE, tsir_pkg::RST_SPARE_SIX, tsir_pkg::RST_SPARE_SEVEN};

    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    logic [3:0] strap_q;
    logic [2:0] pins_q;
    logic [7:0] regs [tsir_pkg::REG_COUNT];
    logic [7:0] next_regs [tsir_pkg::REG_COUNT];
    tsir_pkg::tsir_state_e state;
    tsir_pkg::tsir_state_e next_state;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [2:0] offset;
    logic [2:0] next_offset;
    logic have_offset;
    logic next_have_offset;
    logic drive_low;
    logic next_drive_low;
    logic rd_mode;
    logic next_rd_mode;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic active;
    logic squelched;
    logic [7:0] addr_match;
    logic next_eq_powered;
    logic next_term_connected;
    logic next_bias_override;
    logic next_bias_to_supply;
    logic [2:0] next_eq_gain;
    logic next_squelch_enabled;

    // Bus pins and straps come from outside the clock domain
    tsir_pin_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in({ctrl_bus_clock, ctrl_bus_data_in}),
        .level({scl, sda})
    );
    tsir_pin_sync #(.WIDTH(4), .INIT(4'h0)) u_strap_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in(addr_strap),
        .level(strap_q)
    );
    tsir_pin_sync #(.WIDTH(3), .INIT(3'h0)) u_pin_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_in({control_source_select, output_enable_pin, clock_level_ok}),
        .level(pins_q)
    );

    // Bus edge and condition detection on filtered levels
    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
    assign start_seen = scl & scl_d & sda_d & ~sda;
    assign stop_seen = scl & scl_d & ~sda_d & sda;
    assign addr_match = {tsir_pkg::TARGET_ADDR_UPPER, strap_q, 1'b0};

    // Open-drain data: only ever pull low
    assign ctrl_bus_data_out = 1'b0;
    assign ctrl_bus_data_oe = drive_low;

    // Target sequencer and register writes
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_offset = offset;
        next_have_offset = have_offset;
        next_drive_low = drive_low;
        next_rd_mode = rd_mode;
        for (int i = 0; i < tsir_pkg::REG_COUNT; i++) begin
            next_regs[i] = regs[i];
        end
        if (stop_seen) begin
            next_state = tsir_pkg::TSIR_IDLE;
            next_drive_low = 1'b0;
        end else if (start_seen) begin
            next_state = tsir_pkg::TSIR_ADDR;
            next_bit_cnt = 4'h0;
            next_drive_low = 1'b0;
            next_have_offset = 1'b0;
        end else begin
            case (state)
                tsir_pkg::TSIR_IDLE: begin
                    next_drive_low = 1'b0;
                end
                tsir_pkg::TSIR_ADDR, tsir_pkg::TSIR_WR_BYTE: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        next_bit_cnt = 4'h0;
                        if (state == tsir_pkg::TSIR_ADDR) begin
                            if (shift[7:1] == addr_match[7:1]) begin
                                next_rd_mode = shift[0];
                                next_drive_low = 1'b1;
                                next_state = tsir_pkg::TSIR_ADDR_ACK;
                            end else begin
                                next_state = tsir_pkg::TSIR_IDLE;
                            end
                        end else begin
                            // First data byte after the address is the offset
                            if (!have_offset) begin
                                next_offset = shift[2:0];
                                next_have_offset = 1'b1;
                            end else begin
                                next_regs[offset] = shift;
                                next_offset = offset + 3'h1;
                            end
                            next_drive_low = 1'b1;
                            next_state = tsir_pkg::TSIR_WR_ACK;
                        end
                    end
                end
                tsir_pkg::TSIR_ADDR_ACK, tsir_pkg::TSIR_WR_ACK: begin
                    if (scl_fall) begin
                        if (rd_mode) begin
                            next_shift = regs[offset];
                            next_drive_low = ~regs[offset][7];
                            next_bit_cnt = 4'h1;
                            next_state = tsir_pkg::TSIR_RD_BYTE;
                        end else begin
                            next_drive_low = 1'b0;
                            next_state = tsir_pkg::TSIR_WR_BYTE;
                        end
                    end
                end
                tsir_pkg::TSIR_RD_BYTE: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            next_drive_low = 1'b0;
                            next_offset = offset + 3'h1;
                            next_state = tsir_pkg::TSIR_RD_ACK;
                        end else begin
                            next_drive_low = ~shift[3'h7 - bit_cnt[2:0]];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                tsir_pkg::TSIR_RD_ACK: begin
                    // A controller not-acknowledge ends the read
                    if (scl_rise) begin
                        next_state = sda ? tsir_pkg::TSIR_IDLE : tsir_pkg::TSIR_ADDR_ACK;
                    end
                end
                default: begin
                    next_state = tsir_pkg::TSIR_IDLE;
                end
            endcase
        end
    end

    // Sequencer and register storage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= tsir_pkg::TSIR_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            offset <= 3'h0;
            have_offset <= 1'b0;
            drive_low <= 1'b0;
            rd_mode <= 1'b0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            for (int i = 0; i < tsir_pkg::REG_COUNT; i++) begin
                regs[i] <= RST_VALS[i];
            end
        end else begin
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            offset <= next_offset;
            have_offset <= next_have_offset;
            drive_low <= next_drive_low;
            rd_mode <= next_rd_mode;
            scl_d <= scl;
            sda_d <= sda;
            for (int i = 0; i < tsir_pkg::REG_COUNT; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // Registers power the equalizer and drivers only in bus control mode, and the enable pin overrides
    assign active = pins_q[1] & pins_q[2]
        & regs[tsir_pkg::OFS_GENERAL_CONFIG][tsir_pkg::CFG_NORMAL_BIT];
    assign squelched = ~regs[tsir_pkg::OFS_RECEIVER_SETUP][tsir_pkg::RX_SQ_OFF_BIT]
        & ~pins_q[0];

    // Receiver settings; termination follows the enable pin even in standby
    always_comb begin
        next_eq_powered = active;
        next_term_connected = pins_q[1] & ~regs[tsir_pkg::OFS_RECEIVER_SETUP][tsir_pkg::RX_TERM_OFF_BIT];
        next_bias_override = regs[tsir_pkg::OFS_RECEIVER_SETUP][tsir_pkg::RX_BIAS_EN_BIT];
        next_bias_to_supply = regs[tsir_pkg::OFS_RECEIVER_SETUP][tsir_pkg::RX_BIAS_EN_BIT]
            & regs[tsir_pkg::OFS_RECEIVER_SETUP][tsir_pkg::RX_BIAS_VDD_BIT];
        next_eq_gain = regs[tsir_pkg::OFS_RECEIVER_SETUP][tsir_pkg::RX_EQ_LSB +: 3];
        next_squelch_enabled = ~regs[tsir_pkg::OFS_RECEIVER_SETUP][tsir_pkg::RX_SQ_OFF_BIT];
    end

    // Receiver controls, registered so the analog side never sees a glitch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eq_powered <= 1'b0;
            term_connected <= 1'b0;
            bias_override <= 1'b0;
            bias_to_supply <= 1'b0;
            eq_gain <= 3'h0;
            squelch_enabled <= 1'b0;
        end else begin
            eq_powered <= next_eq_powered;
            term_connected <= next_term_connected;
            bias_override <= next_bias_override;
            bias_to_supply <= next_bias_to_supply;
            eq_gain <= next_eq_gain;
            squelch_enabled <= next_squelch_enabled;
        end
    end

    // One decoder per port, each fed by its own output register plus its enable bit in the general config
    tsir_output_decode u_port1 (
        .core_clk(core_clk),
        .rst(rst),
        .port_enable(regs[tsir_pkg::OFS_GENERAL_CONFIG][tsir_pkg::CFG_PORT1_EN_BIT]),
        .active(active),
        .squelched(squelched),
        .setup(regs[tsir_pkg::OFS_PORT_ONE_OUTPUT_SETUP]),
        .drv_on(p1_on),
        .drv_double_term(p1_double_term),
        .drv_emphasis(p1_emphasis),
        .drv_swing(p1_swing),
        .drv_slew(p1_slew)
    );
    tsir_output_decode u_port2 (
        .core_clk(core_clk),
        .rst(rst),
        .port_enable(regs[tsir_pkg::OFS_GENERAL_CONFIG][tsir_pkg::CFG_PORT2_EN_BIT]),
        .active(active),
        .squelched(squelched),
        .setup(regs[tsir_pkg::OFS_PORT_TWO_OUTPUT_SETUP]),
        .drv_on(p2_on),
        .drv_double_term(p2_double_term),
        .drv_emphasis(p2_emphasis),
        .drv_swing(p2_swing),
        .drv_slew(p2_slew)
    );
endmodule

// [tsir_regs_sva.sv]
`timescale 1ns/1ps
module tsir_regs_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bus pins
    input wire logic ctrl_bus_clock,
    input wire logic ctrl_bus_data_out,
    input wire logic ctrl_bus_data_oe,
    // Control pins
    input wire logic control_source_select,
    input wire logic output_enable_pin,
    input wire logic clock_level_ok,
    // Receiver controls
    input wire logic eq_powered,
    input wire logic term_connected,
    input wire logic bias_override,
    input wire logic bias_to_supply,
    input wire logic squelch_enabled,
    // Port controls
    input wire logic p1_on,
    input wire logic p2_on,
    input wire logic [2:0] p1_emphasis,
    input wire logic [2:0] p2_emphasis,
    input wire logic [1:0] p1_swing,
    input wire logic [1:0] p2_swing
);
    default clocking dck @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Pins must sit past the synchroniser before outputs are judged
    sequence enable_low_s;
        !output_enable_pin [*8];
    endsequence
    sequence mode_low_s;
        !control_source_select [*8];
    endsequence
    sequence weak_clock_s;
        (squelch_enabled && !clock_level_ok) [*8];
    endsequence

    // Bus pin and register output checks
    drive_low_only_a: assert property (ctrl_bus_data_out == 1'b0)
        else $error("data pin driven high");
    ack_scl_low_a: assert property ($changed(ctrl_bus_data_oe) |-> !ctrl_bus_clock)
        else $error("data pin moved while bus clock high");
    bias_gate_a: assert property (bias_to_supply |-> bias_override)
        else $error("bias to supply without override");
    standby_a: assert property ((p1_on || p2_on) |-> eq_powered)
        else $error("driver on in standby");
    enable_low_a: assert property (enable_low_s |-> !eq_powered && !term_connected && !p1_on && !p2_on)
        else $error("outputs alive with enable pin low");
    mode_low_a: assert property (mode_low_s |-> !eq_powered && !p1_on && !p2_on)
        else $error("outputs alive with select pin low");
    squelch_a: assert property (weak_clock_s |-> !p1_on && !p2_on)
        else $error("drivers on while squelched");
    emphasis_cap_a: assert property ((p1_emphasis[2] |-> p1_emphasis[1:0] == 2'b00)
        and (p2_emphasis[2] |-> p2_emphasis[1:0] == 2'b00)) else $error("emphasis code not normalised");
    port_settle_a: assert property ($changed({p1_emphasis, p1_swing, p2_emphasis, p2_swing})
        |-> !ctrl_bus_clock) else $error("port setup moved while bus clock high");
endmodule

// [tsir_regs_tb.sv]
`timescale 1ns/1ps
module tsir_regs_tb;
    logic core_clk;
    logic rst;
    logic scl;
    logic host_low;
    logic sda_oe;
    logic sda_out;
    logic sda;
    logic [3:0] strap;
    logic src_sel;
    logic oen;
    logic ok;
    wire logic [25:0] outs;
    logic [7:0] exp_reg [8];
    logic [7:0] seed;
    int n_errors;
    int n_tests;

    // Open-drain data line with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~host_low;

    tsir_i2c_host #(.QTR(25)) i_host (.core_clk(core_clk), .scl(scl), .sda_low(host_low), .sda(sda));

    tsir_regs i_dut (.core_clk(core_clk), .rst(rst), .ctrl_bus_clock(scl), .ctrl_bus_data_in(sda),
        .ctrl_bus_data_out(sda_out), .ctrl_bus_data_oe(sda_oe), .addr_strap(strap), .control_source_select(src_sel),
        .output_enable_pin(oen), .clock_level_ok(ok), .eq_powered(outs[25]), .term_connected(outs[24]),
        .bias_override(outs[23]), .bias_to_supply(outs[22]), .eq_gain(outs[21:19]), .squelch_enabled(outs[18]),
        .p1_on(outs[17]), .p1_double_term(outs[16]), .p1_emphasis(outs[15:13]), .p1_swing(outs[12:11]),
        .p1_slew(outs[10:9]), .p2_on(outs[8]), .p2_double_term(outs[7]), .p2_emphasis(outs[6:4]),
        .p2_swing(outs[3:2]), .p2_slew(outs[1:0]));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // One port's driver controls; any 1xx emphasis reads as 100
    function automatic logic [8:0] port_bits(input logic on, input logic [7:0] s);
        return {on, s[7], s[6] ? 3'h4 : s[6:4], s[3:2], s[1:0]};
    endfunction
    // Expected controls from the register image and the pins
    function automatic logic [25:0] expect_outs(input logic oe_p, input logic sel_p, input logic clk_ok);
        logic act;
        logic sq;
        act = exp_reg[0][7] & oe_p & sel_p;
        sq = ~exp_reg[1][1] & ~clk_ok;
        return {act, oe_p & ~exp_reg[1][7], exp_reg[1][5], exp_reg[1][5] & exp_reg[1][6], exp_reg[1][4:2],
            ~exp_reg[1][1], port_bits(exp_reg[0][5] & act & ~sq, exp_reg[3]),
            port_bits(exp_reg[0][4] & act & ~sq, exp_reg[4])};
    endfunction

    task automatic check(input logic [25:0] seen, input logic [25:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic reset_image();
        exp_reg = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};
    endtask
    // Sync plus register delay before the controls are judged
    task automatic settle();
        repeat (10) @(negedge core_clk);
        check(outs, expect_outs(oen, src_sel, ok));
    endtask
    task automatic send(input logic [7:0] d, input logic nack_exp);
        logic [8:0] r;
        i_host.byte9({d, 1'b1}, r);
        check({25'h0, r[0]}, {25'h0, nack_exp});
    endtask
    // Burst write; random data when rnd is set, otherwise the fixed value
    task automatic write_seq(input logic [2:0] ofs, input int n, input logic [7:0] fixed, input logic rnd);
        i_host.start();
        send({3'h5, strap, 1'b0}, 1'b0);
        send({5'h0, ofs}, 1'b0);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            exp_reg[3'(ofs + i)] = rnd ? seed : fixed;
            send(exp_reg[3'(ofs + i)], 1'b0);
        end
        i_host.stop();
    endtask
    // Offset set, repeated start, burst read with a final refusal
    task automatic read_seq(input logic [2:0] ofs, input int n);
        logic [8:0] r;
        i_host.start();
        send({3'h5, strap, 1'b0}, 1'b0);
        send({5'h0, ofs}, 1'b0);
        i_host.start();
        send({3'h5, strap, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            i_host.byte9({8'hff, i == n - 1}, r);
            check({18'h0, r[8:1]}, {18'h0, exp_reg[3'(ofs + i)]});
        end
        i_host.stop();
    endtask

    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Watchdog a little past the expected run of about 80000 cycles
    initial begin
        repeat (95000) @(posedge core_clk);
        n_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        n_errors = 0;
        n_tests = 0;
        rst = 1'b1;
        src_sel = 1'b1;
        oen = 1'b1;
        ok = 1'b1;
        seed = lfsr(8'h25);
        strap = seed[3:0];
        reset_image();
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        settle();
        // Random bursts from random offsets, wrapping past the top
        for (int it = 0; it < 3; it++) begin
            seed = lfsr(seed);
            write_seq(seed[2:0], 8, 8'h00, 1'b1);
            settle();
            read_seq(3'h0, 8);
        end
        // Squelch on then off across every pin combination
        write_seq(3'h0, 1, 8'hb0, 1'b0);
        for (int s = 0; s < 2; s++) begin
            write_seq(3'h1, 1, s ? 8'h02 : 8'h60, 1'b0);
            for (int p = 0; p < 8; p++) begin
                {oen, src_sel, ok} = 3'(p);
                settle();
            end
        end
        // Foreign address is left unanswered
        i_host.start();
        send({3'h5, ~strap, 1'b0}, 1'b1);
        i_host.stop();
        // Second reset restores the table values
        rst = 1'b1;
        reset_image();
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        settle();
        read_seq(3'h6, 8);
        summarize();
    end
endmodule

bind tsir_regs tsir_regs_sva i_sva (.core_clk, .rst, .ctrl_bus_clock, .ctrl_bus_data_out, .ctrl_bus_data_oe,
    .control_source_select, .output_enable_pin, .clock_level_ok, .eq_powered, .term_connected, .bias_override,
    .bias_to_supply, .squelch_enabled, .p1_on, .p2_on, .p1_emphasis, .p2_emphasis, .p1_swing, .p2_swing);
